// ===== pss_defs.svh
// Register offsets, field positions, reset values and vectors of the program sequencer
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

`define PSS_OFS_CMD 8'h00
`define PSS_OFS_OPERAND 8'h04
`define PSS_OFS_PC 8'h08
`define PSS_OFS_ACC 8'h0c
`define PSS_OFS_DATA 8'h10
`define PSS_OFS_FLAGS 8'h14
`define PSS_OFS_TABLE_POINTER 8'h18
`define PSS_OFS_TABLE_HIGH_BYTE 8'h1c
`define PSS_OFS_BANK 8'h20
`define PSS_OFS_IRQ_EN 8'h24
`define PSS_OFS_IRQ_REQ 8'h28
`define PSS_OFS_SEQ 8'h2c

`define PSS_CMD_OP_LSB 0
`define PSS_CMD_OP_W 5
`define PSS_CMD_DEST_BIT 5
`define PSS_SEQ_BUSY_BIT 0
`define PSS_IRQ_GLOBAL_BIT 6
`define PSS_NUM_IRQ 6
`define PSS_JUMP_FIELD_W 13
`define PSS_PAGE_W 8
`define PSS_BANK_PC_LSB 5

`define PSS_RST_BYTE 8'h00
`define PSS_RST_IRQ_EN 7'h00
`define PSS_RST_IRQ_REQ 6'h00
`define PSS_RST_OPERAND 13'h0000
`define PSS_VEC_RESET 16'h0000
`define PSS_VEC_FIRST 16'h0004
`define PSS_VEC_STEP 16'h0004

`endif

// ===== pss_pkg.sv
// Types shared by the program sequencer
package pss_pkg;

    typedef enum logic [4:0] {
        PSS_CMD_NOP = 5'h00,
        PSS_CMD_SKIP = 5'h01,
        PSS_CMD_JUMP = 5'h02,
        PSS_CMD_CALL = 5'h03,
        PSS_CMD_RETURN = 5'h04,
        PSS_CMD_INTERRUPT_RETURN = 5'h05,
        PSS_CMD_LOAD_PROG_COUNT_LOW_BYTE = 5'h06,
        PSS_CMD_TABLE_READ_CURRENT_PAGE = 5'h07,
        PSS_CMD_TABLE_READ_LAST_PAGE = 5'h08,
        PSS_CMD_ADD = 5'h09,
        PSS_CMD_ADD_CARRY = 5'h0a,
        PSS_CMD_SUB = 5'h0b,
        PSS_CMD_SUB_BORROW = 5'h0c,
        PSS_CMD_DECIMAL_ADJUST = 5'h0d,
        PSS_CMD_AND = 5'h0e,
        PSS_CMD_OR = 5'h0f,
        PSS_CMD_XOR = 5'h10,
        PSS_CMD_COMPLEMENT = 5'h11,
        PSS_CMD_ROT_RIGHT = 5'h12,
        PSS_CMD_ROT_RIGHT_CARRY = 5'h13,
        PSS_CMD_ROT_LEFT = 5'h14,
        PSS_CMD_ROT_LEFT_CARRY = 5'h15,
        PSS_CMD_INC = 5'h16,
        PSS_CMD_DEC = 5'h17
    } pss_cmd_e;

    // Gray codes along idle, execute, fetch
    typedef enum logic [1:0] {
        PSS_ST_IDLE = 2'h0,
        PSS_ST_EXEC = 2'h1,
        PSS_ST_FETCH = 2'h3
    } pss_state_e;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } pss_flags_s;

endpackage

// ===== pss_core.sv
// Program sequencer: program counter, return stack, vectoring, ALU and table read
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`include "pss_defs.svh"

module pss_core #(
    parameter int PC_W = 15,
    parameter int STACK_DEPTH = 8,
    parameter int PROG_W = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`PSS_NUM_IRQ-1:0] irq_src_i,
    output logic [PC_W-1:0] prog_addr_o,
    output logic prog_rd_o,
    input wire logic [PROG_W-1:0] prog_data_i,
    output logic [PC_W-1:0] pc_o
);

    localparam int LVL_W = $clog2(STACK_DEPTH + 1);
    localparam int NIRQ = `PSS_NUM_IRQ;
    localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(STACK_DEPTH);

    typedef struct packed {
        pss_pkg::pss_state_e st;
        pss_pkg::pss_cmd_e cmd;
        logic [PC_W-1:0] pc;
        logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
        logic [LVL_W-1:0] return_stack_level;
        logic [7:0] acc;
        logic [7:0] data;
        logic [7:0] table_pointer;
        logic [7:0] table_high_byte;
        logic [7:0] memory_bank_pointer;
        logic [`PSS_JUMP_FIELD_W-1:0] operand;
        pss_pkg::pss_flags_s flags;
        logic [NIRQ:0] irq_en;
        logic [NIRQ-1:0] irq_req;
        logic [NIRQ-1:0] irq_prev;
        logic ack;
        logic [31:0] rdata;
        logic [PC_W-1:0] prog_addr;
        logic prog_rd;
    } pss_core_s;

    pss_core_s q;
    pss_core_s next_q;

    // Byte-lane merge of a bus write into a register
    function automatic logic [31:0] pss_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Working values of the combinational step
    logic bus_wr;
    logic cmd_wr;
    logic [31:0] wd;
    logic [NIRQ-1:0] irq_rise;
    logic [NIRQ-1:0] irq_pend;
    logic irq_take;
    logic [15:0] irq_vec;
    int irq_idx;
    logic [15:0] jump_full;
    logic [PC_W-1:0] pc_inc;
    logic [LVL_W-1:0] pop_lvl;
    logic [LVL_W-1:0] push_slot;
    logic [15:0] pword;
    logic [7:0] alu_b;
    logic alu_cin;
    logic [8:0] alu_sum;
    logic [4:0] alu_low;
    logic [7:0] alu_r;
    logic [8:0] daa_t;
    logic alu_wr;
    logic to_data;
    pss_pkg::pss_cmd_e new_cmd;

    always_comb begin
        next_q = q;
        bus_wr = 1'b0;
        cmd_wr = 1'b0;
        wd = 32'h0000_0000;
        irq_pend = '0;
        irq_take = 1'b0;
        irq_vec = `PSS_VEC_RESET;
        irq_idx = 0;
        jump_full = 16'h0000;
        pc_inc = q.pc + PC_W'(1);
        pop_lvl = '0;
        push_slot = '0;
        pword = 16'h0000;
        alu_b = 8'h00;
        alu_cin = 1'b0;
        alu_sum = 9'h000;
        alu_low = 5'h00;
        alu_r = 8'h00;
        daa_t = 9'h000;
        alu_wr = 1'b0;
        to_data = 1'b0;
        new_cmd = pss_pkg::PSS_CMD_NOP;

        // Classic slave: ack one cycle after the request, dropped the next cycle
        next_q.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        next_q.rdata = 32'h0000_0000;
        next_q.prog_rd = 1'b0;
        unique case (wb_adr_i)
            `PSS_OFS_OPERAND: next_q.rdata = 32'(q.operand);
            `PSS_OFS_PC: next_q.rdata = 32'(q.pc);
            `PSS_OFS_ACC: next_q.rdata = 32'(q.acc);
            `PSS_OFS_DATA: next_q.rdata = 32'(q.data);
            `PSS_OFS_FLAGS: next_q.rdata = 32'(q.flags);
            `PSS_OFS_TABLE_POINTER: next_q.rdata = 32'(q.table_pointer);
            `PSS_OFS_TABLE_HIGH_BYTE: next_q.rdata = 32'(q.table_high_byte);
            `PSS_OFS_BANK: next_q.rdata = 32'(q.memory_bank_pointer);
            `PSS_OFS_IRQ_EN: next_q.rdata = 32'(q.irq_en);
            `PSS_OFS_IRQ_REQ: next_q.rdata = 32'(q.irq_req);
            `PSS_OFS_SEQ: next_q.rdata = 32'(q.st != pss_pkg::PSS_ST_IDLE);
            default: next_q.rdata = 32'h0000_0000;
        endcase
        // Read data only in the answer cycle, so the bus idles at zero
        if (!(wb_cyc_i && wb_stb_i && !q.ack)) begin
            next_q.rdata = 32'h0000_0000;
        end
        // Stack contents and level have no address at all

        // Writes take effect at the edge that samples ack
        bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
        if (bus_wr) begin
            unique case (wb_adr_i)
                `PSS_OFS_CMD: begin
                    wd = pss_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                    cmd_wr = wb_sel_i[0];
                end
                `PSS_OFS_OPERAND: begin
                    wd = pss_merge(32'(q.operand), wb_dat_i, wb_sel_i);
                    next_q.operand = wd[`PSS_JUMP_FIELD_W-1:0];
                end
                `PSS_OFS_ACC: begin
                    wd = pss_merge(32'(q.acc), wb_dat_i, wb_sel_i);
                    next_q.acc = wd[7:0];
                end
                `PSS_OFS_DATA: begin
                    wd = pss_merge(32'(q.data), wb_dat_i, wb_sel_i);
                    next_q.data = wd[7:0];
                end
                `PSS_OFS_FLAGS: begin
                    wd = pss_merge(32'(q.flags), wb_dat_i, wb_sel_i);
                    next_q.flags = wd[3:0];
                end
                `PSS_OFS_TABLE_POINTER: begin
                    wd = pss_merge(32'(q.table_pointer), wb_dat_i, wb_sel_i);
                    next_q.table_pointer = wd[7:0];
                end
                `PSS_OFS_BANK: begin
                    wd = pss_merge(32'(q.memory_bank_pointer), wb_dat_i, wb_sel_i);
                    next_q.memory_bank_pointer = wd[7:0];
                end
                `PSS_OFS_IRQ_EN: begin
                    wd = pss_merge(32'(q.irq_en), wb_dat_i, wb_sel_i);
                    next_q.irq_en = wd[NIRQ:0];
                end
                `PSS_OFS_IRQ_REQ: begin
                    // Write one to clear
                    wd = pss_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
                    next_q.irq_req = q.irq_req & ~wd[NIRQ-1:0];
                end
                default: wd = 32'h0000_0000;
            endcase
        end
        new_cmd = pss_pkg::pss_cmd_e'(wd[`PSS_CMD_OP_LSB +: `PSS_CMD_OP_W]);
        to_data = wd[`PSS_CMD_DEST_BIT];

        // Lowest pending source wins; request flag stays set while the stack is full
        irq_pend = q.irq_req & q.irq_en[NIRQ-1:0] & {NIRQ{q.irq_en[`PSS_IRQ_GLOBAL_BIT]}};
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (irq_pend[i]) begin
                irq_idx = i;
                irq_vec = `PSS_VEC_FIRST + 16'(i) * `PSS_VEC_STEP;
            end
        end
        irq_take = (|irq_pend) && (q.return_stack_level != LVL_FULL);

        // Jump target: field bits below, bank pointer bits above
        jump_full = {q.memory_bank_pointer[7:`PSS_BANK_PC_LSB], q.operand};
        // Overflowing push overwrites the oldest slot
        push_slot = (q.return_stack_level == LVL_FULL) ? '0 : q.return_stack_level;
        pop_lvl = (q.return_stack_level == '0) ? LVL_W'(STACK_DEPTH - 1) : q.return_stack_level - LVL_W'(1);
        pword = 16'(prog_data_i);

        unique case (q.st)
            pss_pkg::PSS_ST_IDLE: begin
                if (cmd_wr) begin
                    next_q.cmd = new_cmd;
                    next_q.pc = pc_inc;
                    unique case (new_cmd)
                        pss_pkg::PSS_CMD_SKIP: next_q.pc = q.pc + PC_W'(2);
                        pss_pkg::PSS_CMD_JUMP: begin
                            next_q.pc = jump_full[PC_W-1:0];
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        pss_pkg::PSS_CMD_CALL: begin
                            // Not blocked when full: overflow is the caller's problem
                            next_q.stack[push_slot[$clog2(STACK_DEPTH)-1:0]] = pc_inc;
                            if (q.return_stack_level != LVL_FULL) begin
                                next_q.return_stack_level = q.return_stack_level + LVL_W'(1);
                            end
                            next_q.pc = jump_full[PC_W-1:0];
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        pss_pkg::PSS_CMD_RETURN, pss_pkg::PSS_CMD_INTERRUPT_RETURN: begin
                            next_q.pc = q.stack[pop_lvl[$clog2(STACK_DEPTH)-1:0]];
                            if (q.return_stack_level != '0) begin
                                next_q.return_stack_level = pop_lvl;
                            end
                            if (new_cmd == pss_pkg::PSS_CMD_INTERRUPT_RETURN) begin
                                next_q.irq_en[`PSS_IRQ_GLOBAL_BIT] = 1'b1;
                            end
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        pss_pkg::PSS_CMD_LOAD_PROG_COUNT_LOW_BYTE: begin
                            // Page stays, so the jump reaches only 256 words
                            next_q.pc = {q.pc[PC_W-1:`PSS_PAGE_W], q.operand[`PSS_PAGE_W-1:0]};
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        pss_pkg::PSS_CMD_TABLE_READ_CURRENT_PAGE: begin
                            next_q.prog_addr = {q.pc[PC_W-1:`PSS_PAGE_W], q.table_pointer};
                            next_q.prog_rd = 1'b1;
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        pss_pkg::PSS_CMD_TABLE_READ_LAST_PAGE: begin
                            next_q.prog_addr = {{(PC_W-`PSS_PAGE_W){1'b1}}, q.table_pointer};
                            next_q.prog_rd = 1'b1;
                            next_q.st = pss_pkg::PSS_ST_EXEC;
                        end
                        default: alu_wr = (new_cmd >= pss_pkg::PSS_CMD_ADD) && (new_cmd <= pss_pkg::PSS_CMD_DEC);
                    endcase
                end else if (irq_take) begin
                    // Acknowledge: push next address, vector, mask further nesting
                    next_q.stack[push_slot[$clog2(STACK_DEPTH)-1:0]] = q.pc;
                    next_q.return_stack_level = q.return_stack_level + LVL_W'(1);
                    next_q.pc = irq_vec[PC_W-1:0];
                    next_q.irq_req[irq_idx] = 1'b0;
                    next_q.irq_en[`PSS_IRQ_GLOBAL_BIT] = 1'b0;
                    next_q.cmd = pss_pkg::PSS_CMD_CALL;
                    next_q.st = pss_pkg::PSS_ST_EXEC;
                end
            end
            pss_pkg::PSS_ST_EXEC: begin
                // Dummy cycle while the new address is fetched
                next_q.st = pss_pkg::PSS_ST_FETCH;
            end
            pss_pkg::PSS_ST_FETCH: begin
                if (q.cmd == pss_pkg::PSS_CMD_TABLE_READ_CURRENT_PAGE ||
                    q.cmd == pss_pkg::PSS_CMD_TABLE_READ_LAST_PAGE) begin
                    next_q.data = pword[7:0];
                    next_q.table_high_byte = pword[15:8];
                end
                next_q.st = pss_pkg::PSS_ST_IDLE;
            end
            default: next_q.st = pss_pkg::PSS_ST_IDLE;
        endcase

        // ALU: operand b is the data register, inverted for subtraction
        alu_b = (new_cmd == pss_pkg::PSS_CMD_SUB || new_cmd == pss_pkg::PSS_CMD_SUB_BORROW) ? ~q.data : q.data;
        alu_cin = (new_cmd == pss_pkg::PSS_CMD_SUB) ? 1'b1 :
                  (new_cmd == pss_pkg::PSS_CMD_ADD_CARRY || new_cmd == pss_pkg::PSS_CMD_SUB_BORROW) ? q.flags.c : 1'b0;
        alu_sum = 9'(q.acc) + 9'(alu_b) + 9'(alu_cin);
        alu_low = 5'(q.acc[3:0]) + 5'(alu_b[3:0]) + 5'(alu_cin);
        daa_t = 9'(q.acc);
        if (q.acc[3:0] > 4'h9 || q.flags.ac) begin
            daa_t = daa_t + 9'h006;
        end
        if (daa_t[8:4] > 5'h09 || q.flags.c) begin
            daa_t = daa_t + 9'h060;
        end
        if (alu_wr) begin
            unique case (new_cmd)
                pss_pkg::PSS_CMD_ADD, pss_pkg::PSS_CMD_ADD_CARRY,
                pss_pkg::PSS_CMD_SUB, pss_pkg::PSS_CMD_SUB_BORROW: begin
                    alu_r = alu_sum[7:0];
                    next_q.flags.c = alu_sum[8];
                    next_q.flags.ac = alu_low[4];
                    next_q.flags.ov = (q.acc[7] == alu_b[7]) && (alu_r[7] != q.acc[7]);
                end
                pss_pkg::PSS_CMD_DECIMAL_ADJUST: begin
                    alu_r = daa_t[7:0];
                    next_q.flags.c = q.flags.c | daa_t[8];
                end
                pss_pkg::PSS_CMD_AND: alu_r = q.acc & q.data;
                pss_pkg::PSS_CMD_OR: alu_r = q.acc | q.data;
                pss_pkg::PSS_CMD_XOR: alu_r = q.acc ^ q.data;
                pss_pkg::PSS_CMD_COMPLEMENT: alu_r = ~q.data;
                pss_pkg::PSS_CMD_ROT_RIGHT: alu_r = {q.data[0], q.data[7:1]};
                pss_pkg::PSS_CMD_ROT_RIGHT_CARRY: begin
                    alu_r = {q.flags.c, q.data[7:1]};
                    next_q.flags.c = q.data[0];
                end
                pss_pkg::PSS_CMD_ROT_LEFT: alu_r = {q.data[6:0], q.data[7]};
                pss_pkg::PSS_CMD_ROT_LEFT_CARRY: begin
                    alu_r = {q.data[6:0], q.flags.c};
                    next_q.flags.c = q.data[7];
                end
                pss_pkg::PSS_CMD_INC: alu_r = q.data + 8'h01;
                default: alu_r = q.data - 8'h01;
            endcase
            // Rotates leave zero alone; every other class refreshes it
            if (new_cmd < pss_pkg::PSS_CMD_ROT_RIGHT || new_cmd > pss_pkg::PSS_CMD_ROT_LEFT_CARRY) begin
                next_q.flags.z = (alu_r == 8'h00);
            end
            if (to_data) begin
                next_q.data = alu_r;
            end else begin
                next_q.acc = alu_r;
            end
        end

        // Edge capture last, so a new request beats any clear in the same cycle
        irq_rise = irq_src_i & ~q.irq_prev;
        next_q.irq_prev = irq_src_i;
        next_q.irq_req = next_q.irq_req | irq_rise;
    end

    // State register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            q.st <= pss_pkg::PSS_ST_IDLE;
            q.cmd <= pss_pkg::PSS_CMD_NOP;
            q.pc <= PC_W'(`PSS_VEC_RESET);
            q.stack <= '0;
            q.return_stack_level <= '0;
            q.acc <= `PSS_RST_BYTE;
            q.data <= `PSS_RST_BYTE;
            q.table_pointer <= `PSS_RST_BYTE;
            q.table_high_byte <= `PSS_RST_BYTE;
            q.memory_bank_pointer <= `PSS_RST_BYTE;
            q.operand <= `PSS_RST_OPERAND;
            q.flags <= '0;
            q.irq_en <= `PSS_RST_IRQ_EN;
            q.irq_req <= `PSS_RST_IRQ_REQ;
            q.irq_prev <= `PSS_RST_IRQ_REQ;
            q.ack <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.prog_addr <= '0;
            q.prog_rd <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = q.rdata;
    assign wb_ack_o = q.ack;
    assign prog_addr_o = q.prog_addr;
    assign prog_rd_o = q.prog_rd;
    assign pc_o = q.pc;

endmodule // pss_core

// ===== pss_core_properties.sv
// Concurrent checks on the program sequencer ports
module pss_core_properties #(
    parameter int PC_W = 15,
    parameter int ADDR_W = 8,
    parameter int PROG_W = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [5:0] irq_src_i,
    input wire logic [PC_W-1:0] prog_addr_o,
    input wire logic prog_rd_o,
    input wire logic [PROG_W-1:0] prog_data_i,
    input wire logic [PC_W-1:0] pc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [PC_W-1:0] pc_q;
    logic cmd_q;
    logic cmd_wr;
    // Command write lands at this edge
    assign cmd_wr = wb_ack_o && wb_we_i && wb_adr_i == '0 && wb_sel_i[0];
    // Previous pc and strobe, so pc moves can be told apart by cause
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_q <= '0;
            cmd_q <= 1'b0;
        end else begin
            pc_q <= pc_o;
            cmd_q <= cmd_wr;
        end
    end
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_reset_pc; $fell(reset_i) |-> pc_o == '0 && !prog_rd_o; endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");
    property p_rd_pulse; prog_rd_o |=> !prog_rd_o; endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("table strobe too long");
    property p_last_page; cmd_wr && wb_dat_i[4:0] == 5'h08 |=> prog_rd_o && &prog_addr_o[PC_W-1:8]; endproperty
    a_last_page: assert property (p_last_page) else $error("last page address wrong");
    property p_cur_page;
        cmd_wr && wb_dat_i[4:0] == 5'h07 |=> prog_rd_o && prog_addr_o[PC_W-1:8] == pc_q[PC_W-1:8];
    endproperty
    a_cur_page: assert property (p_cur_page) else $error("current page address wrong");
    property p_low_load; cmd_wr && wb_dat_i[4:0] == 5'h06 |=> pc_o[PC_W-1:8] == pc_q[PC_W-1:8]; endproperty
    a_low_load: assert property (p_low_load) else $error("low byte load left page");
    property p_vector;
        pc_o != pc_q && !cmd_q |-> pc_o[PC_W-1:8] == '0 && pc_o[7:0] inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    endproperty
    a_vector: assert property (p_vector) else $error("pc moved to no vector");
    c_call: cover property (cmd_wr && wb_dat_i[4:0] == 5'h03);
    c_table: cover property (prog_rd_o);
    c_irq: cover property (pc_o != pc_q && !cmd_q);
endmodule // pss_core_properties

// ===== pss_core_test.sv
// Self-checking bench for the program sequencer
module pss_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC_W = 15;
    localparam logic [31:0] PMASK = (32'h1 << PC_W) - 32'h1;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic prog_rd_o;
    logic [5:0] irq_src_i = 6'h00;
    logic [PC_W-1:0] prog_addr_o;
    logic [PC_W-1:0] pc_o;
    logic [15:0] prog_data_i = 16'h0000;
    int fails = 0;
    int num_checks = 0;
    pss_core #(.PC_W(PC_W)) dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .irq_src_i(irq_src_i), .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
        .prog_data_i(prog_data_i), .pc_o(pc_o));
    always #2 clk_i = ~clk_i;
    function automatic logic [15:0] mem(input logic [31:0] a);
        return a[15:0] ^ 16'hc3a5;
    endfunction
    // Program memory answers a cycle late; toggles otherwise so stale words never match
    always @(posedge clk_i) begin
        if (prog_rd_o) prog_data_i <= mem(32'(prog_addr_o));
        else prog_data_i <= ~prog_data_i;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50) check("ack", 32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask
    // Idle gap first so two-cycle work and vectoring settle
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string name);
        logic [31:0] q;
        repeat (3) @(posedge clk_i);
        wb(1'b0, adr, 32'h0, q);
        check(name, q, exp);
    endtask
    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic irq(input int i);
        @(posedge clk_i);
        irq_src_i[i] <= 1'b1;
        repeat (3) @(posedge clk_i);
        irq_src_i <= 6'h00;
    endtask
    task automatic t_reset_map();
        do_reset();
        rd_chk(8'h08, 32'h0, "pc");
        wr(8'h08, 32'h1234);
        rd_chk(8'h08, 32'h0, "pc");
        rd_chk(8'h30, 32'h0, "unmapped");
    endtask
    task automatic t_alu();
        logic [15:0] tab [16] = '{16'h097f, 16'h297f, 16'h0a80, 16'h0beb, 16'h0ceb, 16'h0d95, 16'h0e00, 16'h0f7f,
            16'h107f, 16'h11b5, 16'h1225, 16'h13a5, 16'h1494, 16'h1595, 16'h164b, 16'h1749};
        do_reset();
        foreach (tab[i]) begin
            wr(8'h0c, 32'h35);
            wr(8'h10, 32'h4a);
            wr(8'h14, 32'h1);
            wr(8'h00, 32'(tab[i][15:8]));
            rd_chk(tab[i][13] ? 8'h10 : 8'h0c, 32'(tab[i][7:0]), "alu");
            if (tab[i][15:8] == 8'h0e) rd_chk(8'h14, 32'h5, "flags");
        end
    endtask
    task automatic t_branch();
        do_reset();
        wr(8'h20, 32'ha0);
        wr(8'h04, 32'h1234);
        wr(8'h00, 32'h02);
        rd_chk(8'h08, 32'hb234 & PMASK, "jump");
        wr(8'h20, 32'h0);
        wr(8'h04, 32'h0100);
        wr(8'h00, 32'h03);
        rd_chk(8'h08, 32'h0100, "call");
        wr(8'h00, 32'h04);
        rd_chk(8'h08, 32'hb235 & PMASK, "return");
        wr(8'h04, 32'h77);
        wr(8'h00, 32'h06);
        rd_chk(8'h08, 32'hb277 & PMASK, "low load");
        wr(8'h00, 32'h01);
        wr(8'h00, 32'h00);
        rd_chk(8'h08, 32'hb27a & PMASK, "skip and nop");
        wr(8'h18, 32'h10);
        wr(8'h00, 32'h27);
        rd_chk(8'h10, 32'(mem(32'hb210 & PMASK) & 16'h00ff), "table low");
        rd_chk(8'h1c, 32'(mem(32'hb210 & PMASK) >> 8), "table high");
        wr(8'h18, 32'h06);
        wr(8'h00, 32'h28);
        rd_chk(8'h10, 32'(mem(32'hff06 & PMASK) & 16'h00ff), "last low");
        rd_chk(8'h1c, 32'(mem(32'hff06 & PMASK) >> 8), "last high");
    endtask
    task automatic t_vectors();
        do_reset();
        wr(8'h24, 32'h40);
        irq(0);
        rd_chk(8'h08, 32'h0, "masked pc");
        rd_chk(8'h28, 32'h1, "masked req");
        wr(8'h28, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(8'h24, 32'h40 | (32'h1 << i));
            irq(i);
            rd_chk(8'h08, 32'(4 * (i + 1)), "vector");
            wr(8'h00, 32'h05);
            rd_chk(8'h08, 32'h0, "resume");
        end
    endtask
    task automatic t_full();
        do_reset();
        wr(8'h24, 32'h41);
        for (int k = 0; k < 9; k++) begin
            wr(8'h04, 32'h40 + k);
            wr(8'h00, 32'h03);
        end
        rd_chk(8'h08, 32'h48, "overflow call");
        irq(0);
        rd_chk(8'h08, 32'h48, "held pc");
        rd_chk(8'h28, 32'h1, "held req");
        wr(8'h00, 32'h04);
        rd_chk(8'h08, 32'h04, "late vector");
        rd_chk(8'h28, 32'h0, "req taken");
        wr(8'h00, 32'h05);
        rd_chk(8'h08, 32'h47, "irq return");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        t_reset_map();
        t_alu();
        t_branch();
        t_vectors();
        t_full();
        stop_test();
    end
    // Watchdog well beyond the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        stop_test();
    end
endmodule // pss_core_test
bind pss_core pss_core_properties #(.PC_W(PC_W), .ADDR_W(ADDR_W), .PROG_W(PROG_W)) u_props (.clk_i(clk_i),
    .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_src_i(irq_src_i),
    .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .prog_data_i(prog_data_i), .pc_o(pc_o));
